// File: test/rx_afe_chk.sv
// concurrent checks on the pins between front end and symbol processor
module rx_afe_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // link pins
    input wire logic txSymbolClock,
    input wire logic symbolSyncPulse,
    input wire logic rxGainSelHi,
    input wire logic rxGainSelLo,
    input wire logic loopbackSelect,
    input wire logic [rx_afe_pkg::SAMPLE_W-1:0] rxSampleWord,
    // device analog controls
    input wire logic [1:0] gainCode,
    input wire logic lineConnect
);
    timeunit 1ns;
    timeprecision 1ps;
    import rx_afe_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    localparam int MIN_GAP = 48 * STEP_MIN;
    logic [15:0] gap;
    logic [15:0] sinceChg;
    logic [1:0] chgCnt;
    logic [1:0] falls;
    logic primed;

    // cycles since the last sync rise and since the last word change
    always_ff @(posedge sys_clk)
    begin
        if (srst || $rose(symbolSyncPulse))
            gap <= srst ? 16'hffff : 16'h1;
        else if (gap != 16'hffff)
            gap <= gap + 16'h1;
        if (srst || $changed(rxSampleWord))
            sinceChg <= srst ? 16'hffff : 16'h1;
        else if (sinceChg != 16'hffff)
            sinceChg <= sinceChg + 16'h1;
    end

    // word changes and clock falls counted per symbol
    always_ff @(posedge sys_clk)
    begin
        primed <= !srst && (primed || $rose(symbolSyncPulse));
        if (srst || $rose(symbolSyncPulse))
            chgCnt <= 2'h0;
        else if ($changed(rxSampleWord) && chgCnt != 2'h3)
            chgCnt <= chgCnt + 2'h1;
        if (srst || $rose(symbolSyncPulse))
            falls <= {1'b0, !srst && $fell(txSymbolClock)};
        else if ($fell(txSymbolClock) && falls != 2'h3)
            falls <= falls + 2'h1;
    end

    gain_pins_a: assert property (
        ($stable({rxGainSelHi, rxGainSelLo}))[*4]
        |-> gainCode == {rxGainSelHi, rxGainSelLo})
        else $error("gain code does not follow gain pins");
    loop_cut_a: assert property (
        ($stable(loopbackSelect))[*4] |-> lineConnect == !loopbackSelect)
        else $error("line path does not follow loopback pin");
    word_twice_a: assert property (chgCnt <= 2'h2)
        else $error("more than two sample words in a symbol");
    word_spacing_a: assert property (
        $changed(rxSampleWord) |-> sinceChg >= 16'h0096)
        else $error("sample word not held between updates");
    sync_width_a: assert property (
        $rose(symbolSyncPulse) |=> symbolSyncPulse[*7])
        else $error("sync pulse shorter than one phase step");
    sync_level_a: assert property (
        symbolSyncPulse && $past(symbolSyncPulse) |-> $stable(txSymbolClock))
        else $error("sync pulse off the phase step grid");
    sync_gap_a: assert property (
        $rose(symbolSyncPulse) |-> gap >= MIN_GAP)
        else $error("sync pulses closer than one symbol");
    one_fall_a: assert property (
        $rose(symbolSyncPulse) && primed |-> falls == 2'h1)
        else $error("sync not locked to the symbol clock");

    // main scenarios reached
    cover property ($rose(symbolSyncPulse));
    cover property (chgCnt == 2'h2);
    cover property (loopbackSelect && !lineConnect);
endmodule

// File: test/tb.sv
// self-checking bench: controller and front end joined over the pins
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rx_afe_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic signed [SAMPLE_W-1:0] lineSample = '0;
    logic signed [SAMPLE_W-1:0] hybridSample = '0;
    logic sampleValid = 1'b0;
    logic [1:0] validCnt = 2'h0;
    logic [4:0] address = 5'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rdv, cnt0;
    logic waitrequest, lineConnect;
    logic [1:0] gainCode;
    logic [PERIOD_W-1:0] symbolPeriod;
    int mismatches = 0;
    int n_tests = 0;
    int lag, k;
    int lv[6] = '{100, 100, 100, 100, 8000, -8000};
    int hv[6] = '{20, 20, 20, 256, -100, 100};
    logic [1:0] gv[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    logic lpv[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [1:0] mv[6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h0};

    rx_afe_if pins ();
    rx_afe_device u_rx_afe_device (.sys_clk(sys_clk), .srst(srst),
        .pins(pins.device), .lineSample(lineSample),
        .hybridSample(hybridSample), .sampleValid(sampleValid),
        .gainCode(gainCode), .lineConnect(lineConnect),
        .symbolPeriod(symbolPeriod));
    rx_afe_host u_rx_afe_host (.sys_clk(sys_clk), .srst(srst),
        .pins(pins.host), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    rx_afe_chk u_rx_afe_chk (.sys_clk(sys_clk), .srst(srst),
        .txSymbolClock(pins.txSymbolClock),
        .symbolSyncPulse(pins.symbolSyncPulse),
        .rxGainSelHi(pins.rxGainSelHi), .rxGainSelLo(pins.rxGainSelLo),
        .loopbackSelect(pins.loopbackSelect),
        .rxSampleWord(pins.rxSampleWord), .gainCode(gainCode),
        .lineConnect(lineConnect));

    // free-running system clock
    always #10 sys_clk = ~sys_clk;

    // converter sample strobe every fourth cycle
    always @(posedge sys_clk)
    begin
        validCnt <= validCnt + 2'h1;
        sampleValid <= (validCnt == 2'h0);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic w,
        input logic [31:0] d);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        do
            @(posedge sys_clk);
        while (waitrequest !== 1'b0);
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [4:0] a);
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic wait_sync();
        logic p;
        do
        begin
            p = pins.symbolSyncPulse;
            @(posedge sys_clk);
        end
        while (!(p === 1'b0 && pins.symbolSyncPulse === 1'b1));
    endtask

    // cycles from symbol clock fall to the next sync rise
    task automatic measure(output int n);
        logic c;
        logic s;
        n = 0;
        do
        begin
            c = pins.txSymbolClock;
            s = pins.symbolSyncPulse;
            @(posedge sys_clk);
        end
        while (!(c === 1'b1 && pins.txSymbolClock === 1'b0));
        while (!(s === 1'b0 && pins.symbolSyncPulse === 1'b1))
        begin
            s = pins.symbolSyncPulse;
            @(posedge sys_clk);
            n++;
        end
    endtask

    // expected word: gained difference, floored, saturated to 14 bits
    function automatic logic [31:0] expw(input int i);
        int c;
        int v;
        case (gv[i])
            2'h0: c = COEF_0DB;
            2'h1: c = COEF_3DB25;
            2'h2: c = COEF_6DB;
            default: c = COEF_9DB;
        endcase
        v = (((lpv[i] ? 0 : lv[i]) - hv[i]) * c) >>> COEF_SHIFT;
        if (v > SAMPLE_MAX)
            v = SAMPLE_MAX;
        if (v < SAMPLE_MIN)
            v = SAMPLE_MIN;
        return {18'h0, v[13:0]};
    endfunction

    task automatic run_case(input int i);
        lineSample <= lv[i][13:0];
        hybridSample <= hv[i][13:0];
        wr(REG_CTRL, {26'h0, mv[i], lpv[i], gv[i], 1'b1});
        repeat (3) wait_sync();
        chk({30'h0, gainCode}, {30'h0, gv[i]});
        chk({31'h0, lineConnect}, {31'h0, !lpv[i]});
        chk({16'h0, symbolPeriod}, 32'h180);
        if (i == 0)
        begin
            measure(lag);
            chk(lag, k * 8);
        end
        wait_sync();
        rd(REG_COUNT);
        cnt0 = rdv;
        rd(REG_SAMPLE);
        chk({18'h0, rdv[13:0]}, expw(i));
        chk({31'h0, rdv[16]}, 32'h1);
        rd(REG_SAMPLE);
        chk({31'h0, rdv[16]}, 32'h0);
        wait_sync();
        rd(REG_COUNT);
        chk({16'h0, rdv[15:0] - cnt0[15:0]}, mv[i][1] ? 2 : 1);
    endtask

    // hang guard
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    // two passes: sync on the clock fall, then at the latest step
    initial
    begin
        for (int r = 0; r < 2; r++)
        begin
            k = r * 47;
            srst <= 1'b1;
            repeat (12) @(posedge sys_clk);
            srst <= 1'b0;
            @(posedge sys_clk);
            rd(REG_CTRL);
            chk(rdv, 32'h0);
            rd(REG_STEP);
            chk(rdv, 32'h10);
            byteenable <= 4'he;
            wr(REG_STEP, 32'h20);
            byteenable <= 4'hf;
            rd(REG_STEP);
            chk(rdv, 32'h10);
            wr(REG_STEP, 32'h7);
            rd(REG_STEP);
            chk(rdv, 32'h10);
            wr(REG_STEP, 32'h8);
            rd(REG_STEP);
            chk(rdv, 32'h8);
            wr(REG_PHASE, 32'h30);
            rd(REG_PHASE);
            chk(rdv, 32'h0);
            wr(REG_PHASE, k);
            rd(REG_PHASE);
            chk(rdv, k);
            wr(5'h14, 32'hffffffff);
            rd(5'h14);
            chk(rdv, 32'h0);
            for (int i = 0; i < 6; i++)
                run_case(i);
        end
        wrap_up();
    end
endmodule

// File: verilog/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // pins and synchronised copy
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            stage1 <= '0;
            pinOut <= '0;
        end
        else
        begin
            stage1 <= pinIn;
            pinOut <= stage1;
        end
    end
endmodule

// File: verilog/rx_afe_device.sv
// receive-side digital logic of the front end: gain, decimation, output
// Summary of operation
// - gain pins select 0, 3.25, 6, 9 dB
// - processor makes one sync per symbol, clock-locked
// - sync rises at clock fall plus k/48
// - sync governs decimation and output timing
// - two sample words per symbol period
// - decimation is a fixed 8-tap boxcar at the sample strobe rate
// - processor uses one word per symbol, two in both mode and in unnamed mode 2
// - processor captures first word, or second, both
// - 14-bit two's complement word, bit 13 MSB
// - loopback disconnects line, keeps hybrid input
module rx_afe_device (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // pins to the processor
    rx_afe_if.device pins,
    // converter samples from the modulator
    input wire logic signed [rx_afe_pkg::SAMPLE_W-1:0] lineSample,
    input wire logic signed [rx_afe_pkg::SAMPLE_W-1:0] hybridSample,
    input wire logic sampleValid,
    // analog controls and status
    output logic [1:0] gainCode,
    output logic lineConnect,
    output logic [rx_afe_pkg::PERIOD_W-1:0] symbolPeriod
);
    import rx_afe_pkg::*;

    logic [4:0] pinRaw;
    logic [4:0] pinQ;
    logic clkQ;
    logic syncQ;
    logic gainHiQ;
    logic gainLoQ;
    logic loopQ;
    logic syncPrev;
    logic syncRise;
    logic [PERIOD_W-1:0] periodCnt;
    logic [PERIOD_W-1:0] halfPoint;
    logic secondDone;
    logic secondDue;
    logic signed [14:0] diff;
    logic signed [26:0] product;
    logic signed [26:0] scaled;
    logic signed [13:0] gained;
    logic signed [13:0] taps [TAPS];
    logic signed [16:0] tapSum;
    logic signed [13:0] decimated;
    logic [SAMPLE_W-1:0] outWord;

    // gain multiplier for the pin code
    function automatic logic [10:0] gainCoef(input logic [1:0] code);
        unique case (code)
            GAIN_0DB: gainCoef = COEF_0DB;
            GAIN_3DB25: gainCoef = COEF_3DB25;
            GAIN_6DB: gainCoef = COEF_6DB;
            GAIN_9DB: gainCoef = COEF_9DB;
        endcase
    endfunction

    // clamp a wide value into the signed sample range
    function automatic logic signed [13:0] clamp(input logic signed [26:0] v);
        if (v > 27'(SAMPLE_MAX))
            clamp = SAMPLE_MAX;
        else if (v < 27'(SAMPLE_MIN))
            clamp = SAMPLE_MIN;
        else
            clamp = v[13:0];
    endfunction

    // pins cross into the clock domain
    assign pinRaw = {pins.txSymbolClock, pins.symbolSyncPulse,
                     pins.rxGainSelHi, pins.rxGainSelLo,
                     pins.loopbackSelect};

    pin_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .pinIn(pinRaw),
        .pinOut(pinQ)
    );

    assign clkQ = pinQ[4];
    assign syncQ = pinQ[3];
    assign gainHiQ = pinQ[2];
    assign gainLoQ = pinQ[1];
    assign loopQ = pinQ[0];

    // sync rising edge after synchronisation
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            syncPrev <= 1'b0;
        else
            syncPrev <= syncQ;
    end

    assign syncRise = syncQ & ~syncPrev;

    // symbol period measured between sync edges
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            periodCnt <= '0;
        else if (syncRise)
            periodCnt <= 16'h0001;
        else if (periodCnt != 16'hffff)
            periodCnt <= periodCnt + 16'h0001;
    end

    // half period locates the second word; rate follows the sync
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            halfPoint <= '0;
            symbolPeriod <= '0;
        end
        else if (syncRise)
        begin
            halfPoint <= periodCnt >> 1;
            symbolPeriod <= periodCnt;
        end
    end

    // one second word per symbol
    always_ff @(posedge sys_clk)
    begin
        if (srst || syncRise)
            secondDone <= 1'b0;
        else if (secondDue)
            secondDone <= 1'b1;
    end

    assign secondDue = !secondDone && halfPoint != '0 &&
                       periodCnt == halfPoint;

    // difference amp; line dropped while looped back
    assign diff = (loopQ ? 15'sh0000 : 15'(lineSample)) -
                  15'(hybridSample);
    assign product = 27'(diff) * $signed({16'h0000,
                     gainCoef({gainHiQ, gainLoQ})});
    assign scaled = product >>> COEF_SHIFT;

    // gained sample register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            gained <= '0;
        else if (sampleValid)
            gained <= clamp(scaled);
    end

    // boxcar delay line of gained samples
    generate
        for (genvar i = 0; i < TAPS; i++)
        begin : g_tap
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    taps[i] <= '0;
                else if (sampleValid)
                    taps[i] <= (i == 0) ? gained : taps[(i == 0) ? 0 : i-1];
            end
        end
    endgenerate

    // tap sum, combinational
    always_comb
    begin
        tapSum = '0;
        for (int i = 0; i < TAPS; i++)
            tapSum = tapSum + 17'(taps[i]);
    end

    assign decimated = 14'(tapSum >>> TAP_SHIFT);

    // output word: first at sync edge, second at mid symbol, then held
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            outWord <= '0;
        else if (syncRise || secondDue)
            outWord <= decimated;
    end

    assign pins.rxSampleWord = outWord;

    // analog control outputs
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            gainCode <= GAIN_0DB;
            lineConnect <= 1'b1;
        end
        else
        begin
            gainCode <= {gainHiQ, gainLoQ};
            lineConnect <= ~loopQ;
        end
    end

    // symbol clock level is sampled only for the sync relation
    logic clkAtSync;
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            clkAtSync <= 1'b0;
        else if (syncRise)
            clkAtSync <= clkQ;
    end
endmodule

// File: verilog/rx_afe_host.sv
// symbol processor end: clocks, sync phase, gain pins and capture
module rx_afe_host (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // pins to the front end
    rx_afe_if.host pins,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    import rx_afe_pkg::*;

    logic [5:0] ctrl;
    logic [5:0] phaseK;
    logic [7:0] stepLen;
    logic [7:0] stepCnt;
    logic stepTick;
    logic [5:0] phase;
    logic phaseEnter;
    logic [5:0] syncPhase;
    logic [5:0] capFirst;
    logic [5:0] capSecond;
    logic [SAMPLE_W-1:0] wordQ;
    logic [SAMPLE_W-1:0] sample;
    logic fresh;
    logic [15:0] capCount;
    logic doCapture;
    logic accept;
    logic tx_symbol_clock;
    logic syncOut;
    cap_mode_t mode;

    // add two phase indices modulo one symbol
    function automatic logic [5:0] addPhase(input logic [5:0] a,
                                            input logic [5:0] b);
        logic [6:0] s;
        s = {1'b0, a} + {1'b0, b};
        addPhase = (s >= {1'b0, STEPS}) ? 6'(s - {1'b0, STEPS}) : s[5:0];
    endfunction

    assign mode = cap_mode_t'(ctrl[CTRL_MODE +: 2]);
    assign accept = (read || write) && !waitrequest;

    // one wait cycle per access
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            waitrequest <= 1'b1;
        else
            waitrequest <= !(waitrequest && (read || write));
    end

    // read data loaded as waitrequest drops
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            readdata <= '0;
        else if (read && waitrequest)
        begin
            unique case (address)
                REG_CTRL: readdata <= {26'h0, ctrl};
                REG_PHASE: readdata <= {26'h0, phaseK};
                REG_STEP: readdata <= {24'h0, stepLen};
                REG_SAMPLE: readdata <= {15'h0, fresh, 2'h0, sample};
                REG_COUNT: readdata <= {16'h0, capCount};
                default: readdata <= '0;
            endcase
        end
    end

    // control registers; out-of-range phase or step writes ignored
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctrl <= CTRL_RESET;
            phaseK <= PHASE_RESET;
            stepLen <= STEP_RESET;
        end
        else if (accept && write && byteenable[0])
        begin
            if (address == REG_CTRL)
                ctrl <= writedata[5:0];
            if (address == REG_PHASE && writedata[7:0] < {2'h0, STEPS})
                phaseK <= writedata[5:0];
            if (address == REG_STEP && writedata[7:0] >= STEP_MIN)
                stepLen <= writedata[7:0];
        end
    end

    // phase step enable from the clock divider
    always_ff @(posedge sys_clk)
    begin
        if (srst || !ctrl[CTRL_EN] || stepTick)
            stepCnt <= '0;
        else
            stepCnt <= stepCnt + 8'h01;
    end

    assign stepTick = ctrl[CTRL_EN] && stepCnt == stepLen - 8'h01;

    // 48 steps per symbol
    always_ff @(posedge sys_clk)
    begin
        if (srst || !ctrl[CTRL_EN])
            phase <= '0;
        else if (stepTick)
            phase <= addPhase(phase, 6'h01);
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            phaseEnter <= 1'b0;
        else
            phaseEnter <= stepTick;
    end

    // sync rises k steps after the clock falls at half symbol
    assign syncPhase = addPhase(HALF_STEPS, phaseK);
    assign capFirst = addPhase(syncPhase, CAP_FIRST_OFS);
    assign capSecond = addPhase(syncPhase, CAP_SECOND_OFS);

    // clock and one-step sync pulse, once per symbol
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            tx_symbol_clock <= 1'b0;
            syncOut <= 1'b0;
        end
        else
        begin
            tx_symbol_clock <= ctrl[CTRL_EN] && phase < HALF_STEPS;
            syncOut <= ctrl[CTRL_EN] && phase == syncPhase;
        end
    end

    // gain and loopback pins from control
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pins.rxGainSelHi <= 1'b0;
            pins.rxGainSelLo <= 1'b0;
            pins.loopbackSelect <= 1'b0;
        end
        else
        begin
            pins.rxGainSelHi <= ctrl[CTRL_GAIN_HI];
            pins.rxGainSelLo <= ctrl[CTRL_GAIN_LO];
            pins.loopbackSelect <= ctrl[CTRL_LOOP];
        end
    end

    assign pins.txSymbolClock = tx_symbol_clock;
    assign pins.symbolSyncPulse = syncOut;

    // sample pins cross into the clock domain
    pin_sync #(
        .WIDTH(SAMPLE_W)
    ) u_word_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .pinIn(pins.rxSampleWord),
        .pinOut(wordQ)
    );

    // capture first, second or both words per symbol
    assign doCapture = phaseEnter && ctrl[CTRL_EN] &&
        ((phase == capFirst && mode != CAP_SECOND) ||
         (phase == capSecond && mode != CAP_FIRST));

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sample <= '0;
            capCount <= '0;
        end
        else if (doCapture)
        begin
            sample <= wordQ;
            capCount <= capCount + 16'h0001;
        end
    end

    // fresh flag: a capture beats the clear-on-read
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            fresh <= 1'b0;
        else if (doCapture)
            fresh <= 1'b1;
        else if (accept && read && address == REG_SAMPLE)
            fresh <= 1'b0;
    end
endmodule

// File: verilog/rx_afe_if.sv
// pin-level link between the front end and its symbol processor
interface rx_afe_if;
    import rx_afe_pkg::*;
    logic txSymbolClock;
    logic symbolSyncPulse;
    logic rxGainSelHi;
    logic rxGainSelLo;
    logic loopbackSelect;
    logic [SAMPLE_W-1:0] rxSampleWord;
    modport device (
        input txSymbolClock,
        input symbolSyncPulse,
        input rxGainSelHi,
        input rxGainSelLo,
        input loopbackSelect,
        output rxSampleWord
    );
    modport host (
        output txSymbolClock,
        output symbolSyncPulse,
        output rxGainSelHi,
        output rxGainSelLo,
        output loopbackSelect,
        input rxSampleWord
    );
endinterface

// File: verilog/rx_afe_pkg.sv
// shared constants for the receive front-end device and its controller
package rx_afe_pkg;
    // sample word
    localparam int SAMPLE_W = 14;
    localparam logic signed [13:0] SAMPLE_MAX = 14'sh1fff;
    localparam logic signed [13:0] SAMPLE_MIN = -14'sh2000;
    // gain codes {hi, lo} and Q8 multipliers: 0, 3.25, 6, 9 dB
    localparam logic [1:0] GAIN_0DB = 2'h0;
    localparam logic [1:0] GAIN_3DB25 = 2'h1;
    localparam logic [1:0] GAIN_6DB = 2'h2;
    localparam logic [1:0] GAIN_9DB = 2'h3;
    localparam logic [10:0] COEF_0DB = 11'h100;
    localparam logic [10:0] COEF_3DB25 = 11'h174;
    localparam logic [10:0] COEF_6DB = 11'h1ff;
    localparam logic [10:0] COEF_9DB = 11'h2d1;
    localparam int COEF_SHIFT = 8;
    // decimation boxcar
    localparam int TAPS = 8;
    localparam int TAP_SHIFT = 3;
    // symbol timing: 48 phase steps per symbol
    localparam int PERIOD_W = 16;
    localparam logic [5:0] STEPS = 6'h30;
    localparam logic [5:0] HALF_STEPS = 6'h18;
    localparam logic [5:0] CAP_FIRST_OFS = 6'h0c;
    localparam logic [5:0] CAP_SECOND_OFS = 6'h24;
    localparam logic [7:0] STEP_MIN = 8'h08;
    // controller register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_PHASE = 5'h04;
    localparam logic [4:0] REG_STEP = 5'h08;
    localparam logic [4:0] REG_SAMPLE = 5'h0c;
    localparam logic [4:0] REG_COUNT = 5'h10;
    // reset values
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [5:0] PHASE_RESET = 6'h00;
    localparam logic [7:0] STEP_RESET = 8'h10;
    // ctrl fields and sample register fresh bit
    localparam int CTRL_EN = 0;
    localparam int CTRL_GAIN_LO = 1;
    localparam int CTRL_GAIN_HI = 2;
    localparam int CTRL_LOOP = 3;
    localparam int CTRL_MODE = 4;
    localparam int SAMPLE_FRESH = 16;
    // capture modes
    typedef enum logic [1:0] {
        CAP_FIRST = 2'h0,
        CAP_SECOND = 2'h1,
        CAP_BOTH = 2'h3
    } cap_mode_t;
endpackage
